// ### test/flash_device_model.sv
// behavioural flash device: status register, pin, reset behaviour
`timescale 1ns/10ps
`default_nettype none
module flash_device_model (
  input  wire logic       ref_clk,
  input  wire logic       chip_enable_n,
  input  wire logic       output_enable_n,
  input  wire logic       write_enable_n,
  input  wire logic       reset_powerdown_pin,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe,
  output logic [7:0]      data_in,
  output logic            completion_status_pin
);
  // bench sets result_bits, busy_len and buf_avail per scenario
  logic [7:0] result_bits = 8'h00;
  int         busy_len = 20;
  logic       buf_avail = 1'b1;
  logic [7:0] status = 8'h80;
  logic [7:0] last_cmd = 8'hff;
  logic [7:0] wdat = 8'h00;
  logic [1:0] pin_code = 2'h0;
  logic [6:0] junk = 7'h00;
  logic       second = 1'b0;
  logic       xmode = 1'b0;
  logic       was_erase = 1'b0;
  logic       we_q = 1'b1;
  int         busy_cnt = 0;
  int         pulse_cnt = 0;
  int         hold_cnt = 0;
  always @(posedge ref_clk) begin
    junk <= junk + 7'h35;
    we_q <= write_enable_n;
    if (!chip_enable_n && !write_enable_n && data_oe) begin
      wdat <= data_out;
    end
    if (pulse_cnt > 0) pulse_cnt <= pulse_cnt - 1;
    if (hold_cnt > 0) hold_cnt <= hold_cnt - 1;
    if (!reset_powerdown_pin) begin
      status <= 8'h80;
      second <= 1'b0;
      xmode <= 1'b0;
      if (busy_cnt > 0) hold_cnt <= 3;
      busy_cnt <= 0;
    end else if (busy_cnt > 0) begin
      busy_cnt <= busy_cnt - 1;
      if (busy_cnt == 1) begin
        status <= 8'h80 | result_bits;
        if ((pin_code[0] && was_erase) || (pin_code[1] && !was_erase)) begin
          pulse_cnt <= 5;
        end
      end
    end else if (write_enable_n && !we_q) begin
      if (second) begin
        second <= 1'b0;
        if (last_cmd == 8'hb8) begin
          pin_code <= wdat[1:0];
        end else if (last_cmd != 8'he8) begin
          busy_cnt <= busy_len;
          status <= 8'h00;
          was_erase <= (last_cmd == 8'h20);
        end
      end else begin
        last_cmd <= wdat;
        xmode <= (wdat == 8'he8);
        // buffer write takes a count byte next and stays in extended read
        second <= !(wdat inside {8'h70, 8'h50, 8'hff});
        if (wdat == 8'h50) status <= 8'h80;
      end
    end
  end
  // a released bus shows a changing pattern, never the last value
  always_comb begin
    if (chip_enable_n || output_enable_n || !reset_powerdown_pin) begin
      data_in = {~junk[0], junk};
    end else if (xmode) begin
      data_in = {buf_avail, junk};
    end else if (!status[7]) begin
      data_in = {1'b0, junk};
    end else begin
      data_in = status | {5'h0, junk[1], 1'b0, junk[0]};
    end
  end
  // open drain with pull-up: 1 whenever released
  assign completion_status_pin = !((pin_code == 2'h0 && busy_cnt > 0)
                                   || hold_cnt > 0 || pulse_cnt > 0);
endmodule
`default_nettype wire

// ### test/tb_top.sv
// testbench for the flash status host over its register bus
`timescale 1ns/10ps
`default_nettype none
`include "flash_status_params.svh"
`define CHK(nm, exp, got) \
  begin \
    checked++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("ERROR %s expected %h seen %h", nm, exp, got); \
    end \
  end
module tb_top;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready = 1'b0;
  logic [11:0] s_axi_araddr = 12'h000;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready = 1'b0;
  logic        ce_n, oe_n, we_n, rp, d_oe, sts;
  logic [7:0]  d_out, d_in;
  logic [31:0] rd;
  logic [1:0]  rr;
  logic [7:0]  codes [7] = '{8'h00, 8'h40, 8'h20, 8'h10, 8'h08, 8'h02, 8'h30};
  int          n_errors = 0;
  int          checked = 0;
  always #25 ref_clk = ~ref_clk;
  flash_status_host DUT (
    .ref_clk(ref_clk), .reset_n(reset_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .chip_enable_n(ce_n),
    .output_enable_n(oe_n), .write_enable_n(we_n),
    .reset_powerdown_pin(rp), .data_out(d_out), .data_oe(d_oe),
    .data_in(d_in), .completion_status_pin(sts));
  flash_device_model flash (
    .ref_clk(ref_clk), .chip_enable_n(ce_n), .output_enable_n(oe_n),
    .write_enable_n(we_n), .reset_powerdown_pin(rp), .data_out(d_out),
    .data_oe(d_oe), .data_in(d_in), .completion_status_pin(sts));
  task automatic print_verdict;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic timeout(input int n, input int lim);
    if (n >= lim) begin
      n_errors++;
      $display("ERROR wait expected answer seen none");
      print_verdict();
    end
  endtask
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 100);
    s_axi_bready <= 1'b0;
    timeout(n, 100);
  endtask
  task automatic axi_read(input logic [11:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    int n;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 100);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    timeout(n, 100);
  endtask
  // polls until the sequencer is idle, and done too when asked
  task automatic wait_idle(input logic need_done);
    int n;
    n = 0;
    do begin
      axi_read(`REG_STATUS, rd, rr);
      n++;
    end while (!(rd[7] === 1'b0 && (rd[0] === 1'b1 || !need_done)) && n < 400);
    timeout(n, 400);
  endtask
  task automatic run_op(input logic [31:0] cmd, input logic [31:0] ctrl);
    axi_write(`REG_COMMAND, cmd);
    axi_write(`REG_CONTROL, ctrl);
    wait_idle(1'b1);
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    axi_read(12'h100, rd, rr);
    `CHK("unmapped_resp", 2'h2, rr)
    `CHK("unmapped_data", 32'h0, rd)
    // error flag table, bad sequence last so the event stays unique
    for (int i = 0; i < 7; i++) begin
      flash.result_bits = codes[i] | 8'h05;
      run_op(32'h0000d020, 32'h1);
      `CHK("busy_seen", 1'b1, rd[1])
      `CHK("pin_ready", 1'b1, rd[6])
      axi_read(`REG_RESULT, rd, rr);
      `CHK("result", 8'h80 | codes[i], rd[7:0])
      axi_read(`REG_EVENTS, rd, rr);
      `CHK("bad_seq", codes[i] == 8'h30, rd[0])
    end
    flash.result_bits = 8'h00;
    for (int c = 3; c >= 0; c--) begin
      axi_write(`REG_CONTROL, 32'h9 | (c << 8));
      wait_idle(1'b1);
      `CHK("pin_code", 2'(c), flash.pin_code)
      if (c == 3) begin
        run_op(32'h0000d020, 32'h1);
        axi_read(`REG_RESULT, rd, rr);
        `CHK("pulse_result", 8'h80, rd[7:0])
      end
    end
    for (int b = 0; b < 2; b++) begin
      flash.buf_avail = 1'(b);
      run_op(32'h000000e8, 32'h5);
      axi_read(`REG_RESULT, rd, rr);
      `CHK("xstatus", {1'(b), 7'h00}, rd[15:8])
    end
    flash.busy_len = 3000;
    axi_write(`REG_COMMAND, 32'h0000d020);
    axi_write(`REG_CONTROL, 32'h1);
    repeat (40) @(posedge ref_clk);
    axi_write(`REG_CONTROL, 32'h2);
    wait_idle(1'b0);
    `CHK("aborted", 1'b1, rd[2])
    axi_read(`REG_RESULT, rd, rr);
    `CHK("cleared", 8'h80, rd[7:0])
    flash.busy_len = 20;
    run_op(32'h0000d020, 32'h1);
    axi_read(`REG_RESULT, rd, rr);
    `CHK("after_reset", 8'h80, rd[7:0])
    print_verdict();
  end
endmodule
`default_nettype wire

// ### verilog/flash_status_host.sv
// host controller: issues flash commands, polls status, watches the pin
//
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "flash_status_params.svh"
// Contract
// - ready bit 1 means idle; completion seen from it or the pin.
// - host masks reserved status bits 2 and 0.
// - host masks extended status bits 6 to 0.
// - host flags aborted operations so software reissues them.
module flash_status_host (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             chip_enable_n,
  output logic             output_enable_n,
  output logic             write_enable_n,
  output logic             reset_powerdown_pin,
  output logic [7:0]       data_out,
  output logic             data_oe,
  input  wire logic [7:0]  data_in,
  input  wire logic        completion_status_pin
);
  flash_status_pkg::seq_state_t state;
  flash_status_pkg::pin_mode_t  pin_mode;
  logic [7:0]  command_code;
  logic [7:0]  command_data;
  logic        use_xstatus;
  logic [7:0]  last_status;
  logic [7:0]  last_xstatus;
  logic        busy_seen;
  logic        aborted;
  logic        op_done;
  logic [9:0]  wait_count;
  logic [1:0]  phase;
  logic        pin_ready;
  logic        pin_pulse;
  logic        aw_hold;
  logic        w_hold;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        write_go;
  logic [1:0]  w_data_mode;

  function automatic logic [7:0] merge_byte(input logic [7:0] old,
                                            input logic [7:0] nw,
                                            input logic       en);
    return en ? nw : old;
  endfunction

  pin_watch u_pin_watch (
    .ref_clk               (ref_clk),
    .reset_n               (reset_n),
    .completion_status_pin (completion_status_pin),
    .mode                  (pin_mode),
    .pin_ready             (pin_ready),
    .pin_pulse             (pin_pulse)
  );

  // write channel: address and data taken in either order
  assign write_go = aw_hold && w_hold && !s_axi_bvalid;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_hold       <= 1'b0;
      w_hold        <= 1'b0;
      aw_addr       <= 12'h000;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      s_axi_awready <= !aw_hold && !s_axi_awready;
      s_axi_wready  <= !w_hold && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (write_go) begin
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr == `REG_CONTROL ||
                         aw_addr == `REG_COMMAND) ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // command register; control writes start sequences below
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      command_code <= `CMD_READ_STATUS;
      command_data <= 8'h00;
      pin_mode     <= flash_status_pkg::PIN_LEVEL;
      use_xstatus  <= 1'b0;
    end else if (write_go && aw_addr == `REG_COMMAND) begin
      command_code <= merge_byte(command_code, w_data[7:0], w_strb[0]);
      command_data <= merge_byte(command_data, w_data[15:8], w_strb[1]);
    end else if (write_go && aw_addr == `REG_CONTROL && w_strb[0] &&
                 state == flash_status_pkg::ST_IDLE) begin
      use_xstatus <= w_data[`CTRL_XREAD];
      if (w_data[`CTRL_CONFIG] && w_data[`CTRL_START]) begin
        pin_mode <= flash_status_pkg::pin_mode_t'(w_data[9:8]);
      end
    end
  end

  // read channel
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= 2'h0;
      unique case (s_axi_araddr)
        `REG_CONTROL: s_axi_rdata <= {22'h0, pin_mode, 8'h00};
        `REG_COMMAND: s_axi_rdata <= {16'h0, command_data, command_code};
        `REG_STATUS:  s_axi_rdata <= {24'h0, state != flash_status_pkg::ST_IDLE
                                      && state != flash_status_pkg::ST_DONE,
                                      pin_ready, 3'h0, aborted, busy_seen,
                                      op_done};
        `REG_RESULT:  s_axi_rdata <= {16'h0, last_xstatus, last_status};
        `REG_EVENTS:  s_axi_rdata <= {31'h0, last_status[`BIT_ERASE_ERR] &
                                      last_status[`BIT_PROG_ERR]};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // flash sequencer
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state               <= flash_status_pkg::ST_IDLE;
      phase               <= 2'h0;
      wait_count          <= 10'h000;
      chip_enable_n       <= 1'b1;
      output_enable_n     <= 1'b1;
      write_enable_n      <= 1'b1;
      reset_powerdown_pin <= 1'b1;
      data_out            <= 8'h00;
      data_oe             <= 1'b0;
      last_status         <= 8'h80;
      last_xstatus        <= 8'h00;
      busy_seen           <= 1'b0;
      aborted             <= 1'b0;
      op_done             <= 1'b0;
    end else begin
      unique case (state)
        flash_status_pkg::ST_IDLE: begin
          if (write_go && aw_addr == `REG_CONTROL && w_strb[0]) begin
            op_done <= 1'b0;
            if (w_data[`CTRL_RESET]) begin
              reset_powerdown_pin <= 1'b0;
              wait_count          <= 10'(`RESET_LOW_CYCLES);
              aborted             <= 1'b0;
              state               <= flash_status_pkg::ST_RESET;
            end else if (w_data[`CTRL_START]) begin
              busy_seen  <= 1'b0;
              aborted    <= 1'b0;
              phase      <= w_data[`CTRL_CONFIG] ? 2'h2 : 2'h0;
              data_out   <= w_data[`CTRL_CONFIG] ? `CMD_CONFIG_PIN
                                                 : command_code;
              state      <= flash_status_pkg::ST_CMD;
              chip_enable_n  <= 1'b0;
              write_enable_n <= 1'b0;
              data_oe        <= 1'b1;
              wait_count     <= 10'(`ACCESS_CYCLES);
            end
          end
        end
        flash_status_pkg::ST_CMD: begin
          if (wait_count != 10'h000) begin
            wait_count <= wait_count - 10'h001;
          end else begin
            write_enable_n <= 1'b1;
            chip_enable_n  <= 1'b1;
            data_oe        <= 1'b0;
            wait_count     <= 10'(`ACCESS_CYCLES);
            state          <= flash_status_pkg::ST_CMDGAP;
          end
        end
        flash_status_pkg::ST_CMDGAP: begin
          if (wait_count != 10'h000) begin
            wait_count <= wait_count - 10'h001;
          end else if (phase == 2'h0 || phase == 2'h2) begin
            // second cycle: confirm byte or configuration code
            data_out       <= (phase == 2'h2) ? {6'h00, w_data_mode}
                                              : command_data;
            phase          <= (phase == 2'h2) ? 2'h3 : 2'h1;
            chip_enable_n  <= 1'b0;
            write_enable_n <= 1'b0;
            data_oe        <= 1'b1;
            wait_count     <= 10'(`ACCESS_CYCLES);
            state          <= flash_status_pkg::ST_CMD;
          end else if (phase == 2'h3) begin
            op_done <= 1'b1;
            state   <= flash_status_pkg::ST_DONE;
          end else begin
            chip_enable_n   <= 1'b0;
            output_enable_n <= 1'b0;
            wait_count      <= 10'(`ACCESS_CYCLES);
            state           <= flash_status_pkg::ST_POLL;
          end
        end
        flash_status_pkg::ST_POLL: begin
          if (wait_count != 10'h000) begin
            wait_count <= wait_count - 10'h001;
          end else begin
            chip_enable_n   <= 1'b1;
            output_enable_n <= 1'b1;
            if (use_xstatus) begin
              // buffer bit is no ready bit: one read ends the job
              last_xstatus <= data_in & `XSTATUS_MASK;
              op_done      <= 1'b1;
              state        <= flash_status_pkg::ST_DONE;
            end else if (!data_in[`BIT_READY]) begin
              // busy: the other bits float, keep only the ready bit
              busy_seen   <= 1'b1;
              last_status <= {1'b0, last_status[6:0]};
              state       <= flash_status_pkg::ST_WAIT;
            end else begin
              // flags sampled once, after the sequence
              last_status <= data_in & `STATUS_MASK;
              op_done     <= 1'b1;
              state       <= flash_status_pkg::ST_DONE;
            end
          end
        end
        flash_status_pkg::ST_WAIT: begin
          // a reset while busy aborts the job; software must reissue it
          if (write_go && aw_addr == `REG_CONTROL && w_strb[0] &&
              w_data[`CTRL_RESET]) begin
            reset_powerdown_pin <= 1'b0;
            wait_count          <= 10'(`RESET_LOW_CYCLES);
            aborted             <= 1'b1;
            state               <= flash_status_pkg::ST_RESET;
          // level mode waits for the pin, pulse modes for a pulse
          end else if ((pin_mode == flash_status_pkg::PIN_LEVEL && pin_ready) ||
              pin_pulse || wait_count == 10'h3ff) begin
            chip_enable_n   <= 1'b0;
            output_enable_n <= 1'b0;
            wait_count      <= 10'(`ACCESS_CYCLES);
            state           <= flash_status_pkg::ST_POLL;
          end else begin
            wait_count <= wait_count + 10'h001;
          end
        end
        flash_status_pkg::ST_RESET: begin
          if (wait_count != 10'h000) begin
            wait_count <= wait_count - 10'h001;
          end else begin
            reset_powerdown_pin <= 1'b1;
            last_status         <= 8'h80;
            state               <= flash_status_pkg::ST_DONE;
          end
        end
        flash_status_pkg::ST_DONE: begin
          state <= flash_status_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // configuration code held from the control write that started it
  assign w_data_mode = pin_mode;

  busy_masks_flags_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state == flash_status_pkg::ST_POLL && wait_count == 10'h000 &&
    !data_in[`BIT_READY] |=> last_status[6:0] == $past(last_status[6:0]))
    else $error("status flags changed on a busy read");
  reserved_masked_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    last_status[2] == 1'b0 && last_status[0] == 1'b0)
    else $error("reserved status bit not masked");
  xstatus_masked_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    last_xstatus[6:0] == 7'h00)
    else $error("reserved extended bit not masked");
  reset_clears_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state == flash_status_pkg::ST_RESET && wait_count == 10'h000
    |=> last_status == 8'h80 && reset_powerdown_pin)
    else $error("status not cleared after reset pulse");
  reset_held_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $fell(reset_powerdown_pin) |-> !reset_powerdown_pin [*8])
    else $error("reset pin released too early");
  ready_done_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state == flash_status_pkg::ST_POLL && wait_count == 10'h000 &&
    data_in[`BIT_READY] |=> op_done ##1 state == flash_status_pkg::ST_IDLE)
    else $error("ready status did not end the operation");
  pin_wait_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state == flash_status_pkg::ST_WAIT && pin_mode == flash_status_pkg::PIN_LEVEL
    && pin_ready |=> state == flash_status_pkg::ST_POLL && !output_enable_n)
    else $error("released pin did not trigger a status read");
  abort_flag_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(aborted) |-> !reset_powerdown_pin && $past(busy_seen))
    else $error("abort flagged without reset of a busy operation");
endmodule
`default_nettype wire

// ### verilog/flash_status_params.svh
// timing counts, opcodes and register offsets of the flash status host
`ifndef FLASH_STATUS_PARAMS_SVH
`define FLASH_STATUS_PARAMS_SVH

`define CLK_PERIOD_NS      50
`define ACCESS_TIME_NS     150
`define ACCESS_CYCLES      ((`ACCESS_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_LOW_NS       25000
`define RESET_LOW_CYCLES   ((`RESET_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PULSE_TYP_NS       250
`define PULSE_MIN_CYCLES   (`PULSE_TYP_NS / `CLK_PERIOD_NS / 2)

`define CMD_READ_STATUS    8'h70
`define CMD_CLEAR_STATUS   8'h50
`define CMD_CONFIG_PIN     8'hb8

`define BIT_READY          7
`define BIT_SUSPEND        6
`define BIT_ERASE_ERR      5
`define BIT_PROG_ERR       4
`define BIT_LOW_VOLT       3
`define BIT_PROTECT        1
`define BIT_BUF_AVAIL      7
`define STATUS_MASK        8'hfa
`define XSTATUS_MASK       8'h80

`define REG_CONTROL        12'h000
`define REG_COMMAND        12'h004
`define REG_STATUS         12'h008
`define REG_RESULT         12'h00c
`define REG_EVENTS         12'h010

`define CTRL_START         0
`define CTRL_RESET         1
`define CTRL_XREAD         2
`define CTRL_CONFIG        3

`endif

// ### verilog/flash_status_pkg.sv
// types shared by the flash status host
`default_nettype none
package flash_status_pkg;
  typedef enum logic [6:0] {
    ST_IDLE   = 7'h01,
    ST_CMD    = 7'h02,
    ST_CMDGAP = 7'h04,
    ST_POLL   = 7'h08,
    ST_WAIT   = 7'h10,
    ST_RESET  = 7'h20,
    ST_DONE   = 7'h40
  } seq_state_t;

  typedef enum logic [1:0] {
    PIN_LEVEL   = 2'h0,
    PIN_ERASE   = 2'h1,
    PIN_PROGRAM = 2'h2,
    PIN_EITHER  = 2'h3
  } pin_mode_t;
endpackage
`default_nettype wire

// ### verilog/pin_watch.sv
// filter and classifier for the completion pin
`timescale 1ns/10ps
`default_nettype none
`include "flash_status_params.svh"
module pin_watch (
  input  wire logic                       ref_clk,
  input  wire logic                       reset_n,
  input  wire logic                       completion_status_pin,
  input  wire flash_status_pkg::pin_mode_t mode,
  output logic                            pin_ready,
  output logic                            pin_pulse
);
  logic [3:0] low_count;
  logic       pin_q;

  // level mode: high means idle; pulse mode: short low marks completion
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_q     <= 1'b1;
      low_count <= 4'h0;
      pin_pulse <= 1'b0;
      pin_ready <= 1'b1;
    end else begin
      pin_q     <= completion_status_pin;
      pin_ready <= (mode == flash_status_pkg::PIN_LEVEL) ? pin_q : 1'b1;
      pin_pulse <= 1'b0;
      if (!pin_q) begin
        if (low_count != 4'hf) begin
          low_count <= low_count + 4'h1;
        end
      end else begin
        // a glitch shorter than the minimum is not counted
        if (mode != flash_status_pkg::PIN_LEVEL &&
            low_count >= 4'(`PULSE_MIN_CYCLES)) begin
          pin_pulse <= 1'b1;
        end
        low_count <= 4'h0;
      end
    end
  end

  pulse_only_high_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    pin_pulse |-> $past(pin_q) && $past(low_count) != 4'h0)
    else $error("pulse seen without a low phase");
endmodule
`default_nettype wire
